// ===== bench/adc_config_field_decode_tb_top.sv
// self-checking bench for the converter setup decode block
`timescale 1ns/10ps
`include "adc_setup_cfg.svh"

module adc_config_field_decode_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic conv_active = 1'b0;
    logic ref_low = 1'b0;
    adc_setup_pkg::core_ctrl_t core_ctrl;
    logic [9:0] channel_enable_bits;
    logic [3:0] status_channel_code;
    logic result_strobe;
    logic ref_missing_flag;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    logic [31:0] rd;
    logic [31:0] d;
    logic [3:0] code;
    logic [2:0] gb;
    logic [7:0] gains [8] = '{8'h01, 8'h00, 8'h00, 8'h08,
                              8'h10, 8'h20, 8'h40, 8'h80};

    adc_config_field_decode i_adc_config_field_decode (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .conv_active(conv_active),
        .ref_low(ref_low),
        .core_ctrl(core_ctrl),
        .channel_enable_bits(channel_enable_bits),
        .status_channel_code(status_channel_code),
        .result_strobe(result_strobe),
        .ref_missing_flag(ref_missing_flag)
    );

    always #12.5 hclk = ~hclk;

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1)
            num_errors++;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask

    // strobe seen at the edge that ends its cycle; cyc counts edges
    task automatic wait_strobe(output int cyc, output logic [3:0] c);
        cyc = 0;
        do
        begin
            @(posedge hclk);
            cyc++;
        end
        while (result_strobe !== 1'b1 && cyc < 300);
        c = status_channel_code;
        if (cyc >= 300)
            num_errors++;
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`SETUP_REG_OFF, {8'h00, `SETUP_RESET});
        chk({24'h0, core_ctrl.gain_value}, 32'h80);
        for (int g = 0; g < 8; g++)
        begin
            gb = g[2:0];
            // burnout only with the buffer on; one channel; reserved bit 0
            d = {13'h0, gb[0], 10'h001, gb[1] & gb[2], 2'b00, gb[2],
                 ~gb[0], gb};
            wr(`SETUP_REG_OFF, d);
            @(posedge hclk);
            #1;
            chk({30'h0, core_ctrl.pseudo_mode, core_ctrl.burnout_en},
                {30'h0, gb[0], gb[1] & gb[2]});
            chk({30'h0, core_ctrl.buffer_en, core_ctrl.unipolar},
                {30'h0, gb[2], ~gb[0]});
            chk({29'h0, core_ctrl.gain_select}, {29'h0, gb});
            chk({23'h0, core_ctrl.gain_reserved, core_ctrl.gain_value},
                {23'h0, (gb == 3'h1) || (gb == 3'h2), gains[gb]});
            rd_chk(`SETUP_REG_OFF, d);
        end
        // upper bits are not stored; chop and reserved bit kept clear
        wr(`SETUP_REG_OFF, 32'hFF7FFFDF);
        rd_chk(`SETUP_REG_OFF, 32'h0007FFDF);
        chk({22'h0, channel_enable_bits}, 32'h000003FF);
        wr(8'h08, 32'hFFFFFFFF);
        rd_chk(8'h08, 32'h00000000);
        // channel 1 plus short: ascending, wrapping, full settle each
        wr(`SETUP_REG_OFF, 32'h00020210);
        conv_active <= 1'b1;
        wait_strobe(n, code);
        chk({28'h0, code}, 32'h1);
        wait_strobe(n, code);
        chk({28'h0, code}, 32'h9);
        chk(n, `SETTLE_CYC);
        wait_strobe(n, code);
        chk({28'h0, code}, 32'h1);
        chk(n, `SETTLE_CYC);
        // abort mid-settle of the short channel: restart from channel 1
        repeat (40) @(posedge hclk);
        conv_active <= 1'b0;
        repeat (4) @(posedge hclk);
        conv_active <= 1'b1;
        wait_strobe(n, code);
        chk({28'h0, code}, 32'h1);
        chk({31'h0, n >= `SETTLE_CYC}, 32'h1);
        rd_chk(`STATUS_REG_OFF, 32'h00000021);
        // reference detect, only updated while converting
        wr(`SETUP_REG_OFF, 32'h00000150);
        ref_low <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
        chk({31'h0, ref_missing_flag}, 32'h1);
        bus(1'b0, `STATUS_REG_OFF, 32'h0, rd);
        chk({31'h0, rd[`S_REFMISS]}, 32'h1);
        conv_active <= 1'b0;
        ref_low <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
        chk({31'h0, ref_missing_flag}, 32'h1);
        conv_active <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
        chk({31'h0, ref_missing_flag}, 32'h0);
        ref_low <= 1'b1;
        wr(`SETUP_REG_OFF, 32'h00000110);
        repeat (3) @(posedge hclk);
        #1;
        chk({31'h0, ref_missing_flag}, 32'h0);
        // second reset in mid-run restores defaults
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`SETUP_REG_OFF, {8'h00, `SETUP_RESET});
        tally_and_finish();
    end

    // whole run is well under two thousand cycles
    initial
    begin
        #(25 * 20000);
        num_errors++;
        tally_and_finish();
    end
endmodule

// ===== rtl/adc_config_field_decode.sv
// setup register decode, channel sequencer and reference detect
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "adc_setup_cfg.svh"

// Contract
// - pseudo bit 1: eight pseudo differential inputs; 0: four differential
// - several channels may be enabled; each converted in turn automatically
// - sequenced conversions wait full settling; no partial result
// - burnout bit switches the 500 nA test currents on and off
// - detect enabled: flag raised when reference open or below 0.6 V
// - reference detect updates the flag only while the converter is active
// - buffer bit places a buffer ahead of the inputs
// - polarity bit set selects unipolar, cleared selects bipolar coding
// - three lowest bits select the programmable gain
// - gain codes 0,3..7 give 1,8,16,32,64,128; codes 1,2 reserved
// - enables 0..7 report codes 0..7, temperature 8, short 9
module adc_config_field_decode (
    input wire logic hclk, // 40 MHz clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    input wire logic conv_active, // converter core converting
    input wire logic ref_low, // reference open or below threshold
    output adc_setup_pkg::core_ctrl_t core_ctrl, // decoded controls
    output logic [9:0] channel_enable_bits, // enabled channels
    output logic [3:0] status_channel_code, // channel of the last settled result
    output logic result_strobe, // settled result ready, one cycle
    output logic ref_missing_flag // reference missing
);
    default clocking cb_chk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // helpers
    function automatic logic [7:0] gain_of(input logic [2:0] g);
        case (g)
            3'h0: return 8'h01;
            3'h3: return 8'h08;
            3'h4: return 8'h10;
            3'h5: return 8'h20;
            3'h6: return 8'h40;
            3'h7: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction

    // circular search for the next enabled channel after cur
    function automatic logic [3:0] next_chan(input logic [9:0] en,
                                             input logic [3:0] cur);
        logic [3:0] res;
        logic found;
        logic [4:0] idx;
        res = cur;
        found = 1'b0;
        for (int i = 1; i <= `NUM_CHAN; i++)
        begin
            idx = 5'(cur) + 5'(i);
            if (idx >= 5'h0A)
                idx = idx - 5'h0A;
            if (!found && en[idx[3:0]])
            begin
                res = idx[3:0];
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // ==========================================================
    // bus slave: zero wait state, address captured in address phase
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] waddr_ff, nxt_waddr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [`SETUP_W-1:0] setup_ff, nxt_setup;
    logic addr_ok;
    logic wr_setup;
    adc_setup_pkg::seq_state_t seq_ff, nxt_seq;
    logic [31:0] status_word;
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_setup = wr_pend_ff && (waddr_ff == `SETUP_REG_OFF);
    assign status_word = {26'h0, seq_ff == adc_setup_pkg::SEQ_SETTLE,
                          ref_missing_flag, status_channel_code};
    always_comb
    begin
        nxt_wr_pend = addr_ok && hwrite;
        nxt_waddr = addr_ok ? haddr : waddr_ff;
        nxt_rdata = rdata_ff;
        if (addr_ok && !hwrite)
        begin
            case (haddr)
                `SETUP_REG_OFF: nxt_rdata = {8'h00, setup_ff};
                `STATUS_REG_OFF: nxt_rdata = status_word;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        // fields hold until software rewrites them
        nxt_setup = setup_ff;
        if (wr_setup)
            nxt_setup = hwdata[`SETUP_W-1:0] & `SETUP_WR_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            waddr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            setup_ff <= `SETUP_RESET;
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            waddr_ff <= nxt_waddr;
            rdata_ff <= nxt_rdata;
            setup_ff <= nxt_setup;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // decoded controls to the converter core
    always_comb
    begin
        core_ctrl.pseudo_mode = setup_ff[`F_PSEUDO];
        core_ctrl.burnout_en = setup_ff[`F_BURN];
        core_ctrl.ref_missing_detect_enable = setup_ff[`F_REF_MISSING_DETECT_ENABLE];
        core_ctrl.buffer_en = setup_ff[`F_BUF];
        core_ctrl.unipolar = setup_ff[`F_UNIPOLAR];
        core_ctrl.gain_select = setup_ff[`F_GAIN_HI:`F_GAIN_LO];
        core_ctrl.gain_value = gain_of(core_ctrl.gain_select);
        core_ctrl.gain_reserved = (core_ctrl.gain_value == 8'h00);
    end
    assign channel_enable_bits = setup_ff[`F_CHAN_HI:`F_CHAN_LO];

    // ==========================================================
    // channel sequencer; a setup write restarts settling so no
    // partially settled result ever leaves the block
    logic [`CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [3:0] chan_ff, nxt_chan;
    logic strobe_ff, nxt_strobe;

    always_comb
    begin
        nxt_seq = seq_ff;
        nxt_cnt = cnt_ff;
        nxt_chan = chan_ff;
        nxt_strobe = 1'b0;
        case (seq_ff)
            adc_setup_pkg::SEQ_IDLE:
            begin
                nxt_cnt = '0;
                nxt_chan = next_chan(channel_enable_bits, 4'h9);
                if (conv_active && |channel_enable_bits && !wr_setup)
                    nxt_seq = adc_setup_pkg::SEQ_SETTLE;
            end
            adc_setup_pkg::SEQ_SETTLE:
            begin
                if (!conv_active || wr_setup || !(|channel_enable_bits))
                    nxt_seq = adc_setup_pkg::SEQ_IDLE;
                else if (cnt_ff == `CNT_W'(`SETTLE_CYC - 1))
                begin
                    nxt_cnt = '0;
                    nxt_strobe = 1'b1;
                    nxt_chan = next_chan(channel_enable_bits, chan_ff);
                end
                else
                    nxt_cnt = cnt_ff + `CNT_W'(1);
            end
            default: nxt_seq = adc_setup_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seq_ff <= adc_setup_pkg::SEQ_IDLE;
            cnt_ff <= '0;
            chan_ff <= 4'h0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            seq_ff <= nxt_seq;
            cnt_ff <= nxt_cnt;
            chan_ff <= nxt_chan;
            strobe_ff <= nxt_strobe;
        end
    end

    // code of the result just settled (channel index equals its code)
    logic [3:0] code_ff, nxt_code;
    assign nxt_code = nxt_strobe ? chan_ff : code_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            code_ff <= 4'h0;
        else
            code_ff <= nxt_code;
    end
    assign status_channel_code = code_ff;
    assign result_strobe = strobe_ff;

    // ==========================================================
    // reference detect: frozen while converter idle
    logic ref_ff, nxt_ref;
    always_comb
    begin
        nxt_ref = ref_ff;
        if (conv_active)
            nxt_ref = core_ctrl.ref_missing_detect_enable && ref_low;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ref_ff <= 1'b0;
        else
            ref_ff <= nxt_ref;
    end
    assign ref_missing_flag = ref_ff;

    // ==========================================================
    // checks
    logic [`CNT_W-1:0] since_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            since_ff <= '0;
        else if (seq_ff != adc_setup_pkg::SEQ_SETTLE || nxt_strobe)
            since_ff <= '0;
        else if (since_ff != '1)
            since_ff <= since_ff + `CNT_W'(1);
    end

    property p_pseudo;
        wr_setup |=> core_ctrl.pseudo_mode == $past(hwdata[`F_PSEUDO]);
    endproperty
    a_pseudo: assert property (p_pseudo) else $error("pseudo wrong");
    property p_seq_en;
        result_strobe |-> channel_enable_bits[status_channel_code];
    endproperty
    a_seq_en: assert property (p_seq_en) else $error("disabled chan");
    property p_settle;
        result_strobe |-> $past(since_ff) == `CNT_W'(`SETTLE_CYC - 1);
    endproperty
    a_settle: assert property (p_settle) else $error("not settled");
    property p_burn;
        wr_setup |=> core_ctrl.burnout_en == $past(hwdata[`F_BURN]);
    endproperty
    a_burn: assert property (p_burn) else $error("burnout wrong");
    property p_ref_missing_detect_enable;
        conv_active && core_ctrl.ref_missing_detect_enable && ref_low
            |=> ref_missing_flag;
    endproperty
    a_ref_missing_detect_enable: assert property (p_ref_missing_detect_enable) else $error("ref flag missed");
    property p_ref_idle;
        !conv_active |=> $stable(ref_missing_flag);
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("flag moved");
    property p_buf_pol;
        wr_setup |=> core_ctrl.buffer_en == $past(hwdata[`F_BUF])
            && core_ctrl.unipolar == $past(hwdata[`F_UNIPOLAR]);
    endproperty
    a_buf_pol: assert property (p_buf_pol) else $error("buf/pol wrong");
    property p_gain;
        core_ctrl.gain_select == 3'h5 |-> core_ctrl.gain_value == 8'h20;
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");
    property p_code;
        result_strobe |-> status_channel_code <= 4'h9;
    endproperty
    a_code: assert property (p_code) else $error("bad channel code");
    property p_hold;
        !wr_setup |=> $stable(setup_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("setup changed");

    c_two_results: cover property (result_strobe ##[1:200] result_strobe);
    c_ref_flag: cover property ($rose(ref_missing_flag));
    c_restart: cover property (
        seq_ff == adc_setup_pkg::SEQ_SETTLE && wr_setup);

endmodule

// ===== rtl/adc_setup_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADC_SETUP_CFG_SVH
`define ADC_SETUP_CFG_SVH

// ==========================================================
// register map (byte addresses)
`define SETUP_REG_OFF 8'h00
`define STATUS_REG_OFF 8'h04

// ==========================================================
// setup register fields
`define SETUP_W 24
`define SETUP_RESET 24'h000117
`define SETUP_WR_MASK 24'h07FFFF
`define F_PSEUDO 18
`define F_CHAN_HI 17
`define F_CHAN_LO 8
`define F_BURN 7
`define F_REF_MISSING_DETECT_ENABLE 6
`define F_RSVD 5
`define F_BUF 4
`define F_UNIPOLAR 3
`define F_GAIN_HI 2
`define F_GAIN_LO 0

// ==========================================================
// status register fields
`define S_CHAN_HI 3
`define S_CHAN_LO 0
`define S_REFMISS 4
`define S_RUNNING 5

// ==========================================================
// timing
`define CLK_NS 25
`define SETTLE_NS 2000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 16
`define NUM_CHAN 10

`endif

// ===== rtl/adc_setup_pkg.sv
// types shared by the converter setup decode block
package adc_setup_pkg;

    typedef enum logic {SEQ_IDLE, SEQ_SETTLE} seq_state_t;

    typedef struct packed {
        logic pseudo_mode;
        logic burnout_en;
        logic ref_missing_detect_enable;
        logic buffer_en;
        logic unipolar;
        logic [2:0] gain_select;
        logic [7:0] gain_value;
        logic gain_reserved;
    } core_ctrl_t;

endpackage
